// >>> hdl/wdt_pkg.sv
package wdt_pkg;

  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // start value and counter geometry
  localparam int SV_W = 16;
  localparam int OFS_W = 8;
  localparam int CNT_W = SV_W + OFS_W;

  // register offsets
  localparam logic [ADDR_W-1:0] START_VALUE_ADDR = 8'haf;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'hb0;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'hb1;

  // reset values
  localparam logic [SV_W-1:0] START_VALUE_RST = 16'h0000;
  localparam logic RET_CLR_EN_RST = 1'b1;

  // control register fields
  localparam int CTRL_RET_CLR_BIT = 0;

  // status register fields
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_WPTR_BIT = 1;
  localparam int STAT_RPTR_BIT = 2;

  // low frequency clock and timeout figures
  localparam int LF_CLK_HZ = 32768;
  localparam int MIN_TIMEOUT_NS = 7812500;
  localparam int MAX_TIMEOUT_S = 512;
  localparam int TICKS_PER_UNIT = 2 ** OFS_W;

  // byte pointer of the start value register
  typedef enum logic {
    WDT_BYTE_LOW,
    WDT_BYTE_HIGH
  } wdt_byte_t;

  // last access kind seen on the start value register
  typedef enum logic {
    WDT_OP_READ,
    WDT_OP_WRITE
  } wdt_op_t;

endpackage

// >>> hdl/wdt_counter.sv
`timescale 1ns/1ps

// down-counter running on low frequency ticks, with a full wrap from zero
module wdt_counter #(
  parameter int CNT_W = 24
) (
  input wire logic clk_i,              // system clock
  input wire logic rstn_i,             // synchronous reset, active low
  input wire logic ce_i,               // clock enable
  input wire logic clear_i,            // stop and zero the counter
  input wire logic load_i,             // load and start
  input wire logic [CNT_W-1:0] load_val_i, // value loaded
  input wire logic tick_i,             // one low frequency tick
  output logic run_o,                  // counting
  output logic [CNT_W-1:0] count_o,    // present count
  output logic expire_o                // one-cycle pulse on reaching zero
);

  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  logic [CNT_W-1:0] count_r;
  logic run_r;
  logic expire_r;

  assign count_o = count_r;
  assign run_o = run_r;
  assign expire_o = expire_r;

  // a load of zero counts through the wrap, so zero never means off
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      count_r <= '0;
      run_r <= 1'b0;
      expire_r <= 1'b0;
    end else if (ce_i) begin
      expire_r <= 1'b0;
      if (clear_i) begin
        count_r <= '0;
        run_r <= 1'b0;
      end else if (load_i) begin
        count_r <= load_val_i;
        run_r <= 1'b1;
      end else if (run_r && tick_i) begin
        count_r <= count_r - CNT_ONE;
        if (count_r == CNT_ONE) begin
          expire_r <= 1'b1;
          run_r <= 1'b0;
        end
      end
    end
  end

endmodule

// >>> hdl/wdt_top.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps

module wdt_top #(
  parameter int SV_W = wdt_pkg::SV_W,
  parameter int OFS_W = wdt_pkg::OFS_W
) (
  input wire logic CLOCK_I,                          // 40 MHz system clock
  input wire logic RSTN_I,                           // sync reset, active low
  input wire logic CE_I,                             // clock enable
  input wire logic LF_TICK_I,                        // 32.768 kHz tick pulse
  input wire logic RET_ENTRY_I,                      // retention mode entry
  input wire logic [wdt_pkg::ADDR_W-1:0] ADDR_I,     // register address
  input wire logic [wdt_pkg::DATA_W-1:0] WDATA_I,    // write data
  input wire logic WR_I,                             // write strobe
  input wire logic RD_I,                             // read strobe
  output logic [wdt_pkg::DATA_W-1:0] RDATA_O,        // read data, next cycle
  output logic WDT_ACTIVE_O,                         // watchdog counting
  output logic WDT_RESET_O                           // system reset request
);

  localparam int CNT_W = SV_W + OFS_W;

  //////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // the byte-pair access only serves a start value of two bus bytes
  generate
    if (SV_W != 2 * wdt_pkg::DATA_W) begin : g_bad_sv
      $error("start value width must be two data bytes");
    end
    if (OFS_W < 1) begin : g_bad_ofs
      $error("counter offset must be at least one bit");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // declarations

  logic [SV_W-1:0] start_value_r;
  logic [wdt_pkg::DATA_W-1:0] low_stage_r;
  logic [wdt_pkg::DATA_W-1:0] rdata_r;
  wdt_pkg::wdt_byte_t ptr_r;
  wdt_pkg::wdt_byte_t ptr_eff;
  wdt_pkg::wdt_op_t op_r;
  wdt_pkg::wdt_op_t op_now;
  logic ret_clr_en_r;
  logic reset_req_r;
  logic active_r;
  logic sv_hit;
  logic sv_wr;
  logic sv_rd;
  logic commit;
  logic ret_clear;
  logic cnt_run;
  logic cnt_expire;
  logic [CNT_W-1:0] load_val;

  //////////////////////////////////////////////////////////////////////////
  // access decode

  assign sv_hit = (ADDR_I == wdt_pkg::START_VALUE_ADDR);
  assign sv_wr = WR_I && sv_hit;
  assign sv_rd = RD_I && sv_hit;
  assign op_now = WR_I ? wdt_pkg::WDT_OP_WRITE : wdt_pkg::WDT_OP_READ;

  // a change of direction restarts at the low byte
  always_comb begin
    if (op_now == op_r) begin
      ptr_eff = ptr_r;
    end else begin
      ptr_eff = wdt_pkg::WDT_BYTE_LOW;
    end
  end

  // the high byte write completes the pair and starts the count
  assign commit = sv_wr && (ptr_eff == wdt_pkg::WDT_BYTE_HIGH);

  // retention clear only when software has left the option on
  assign ret_clear = RET_ENTRY_I && ret_clr_en_r;

  // eight zero bits under the start value
  assign load_val = {WDATA_I, low_stage_r, {OFS_W{1'b0}}};

  //////////////////////////////////////////////////////////////////////////
  // byte pointer

  // reads and writes keep one pointer; the direction bit decides reuse
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      ptr_r <= wdt_pkg::WDT_BYTE_LOW;
      op_r <= wdt_pkg::WDT_OP_WRITE;
    end else if (CE_I) begin
      if (ret_clear) begin
        ptr_r <= wdt_pkg::WDT_BYTE_LOW;
      end else if (sv_wr || sv_rd) begin
        op_r <= op_now;
        if (ptr_eff == wdt_pkg::WDT_BYTE_LOW) begin
          ptr_r <= wdt_pkg::WDT_BYTE_HIGH;
        end else begin
          ptr_r <= wdt_pkg::WDT_BYTE_LOW;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // start value storage

  // the low byte waits in a stage so a lone low write never half-loads
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      low_stage_r <= '0;
      start_value_r <= wdt_pkg::START_VALUE_RST;
    end else if (CE_I) begin
      if (sv_wr && ptr_eff == wdt_pkg::WDT_BYTE_LOW) begin
        low_stage_r <= WDATA_I;
      end
      if (commit) begin
        start_value_r <= {WDATA_I, low_stage_r};
      end
    end
  end

  // control register: retention clear option
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      ret_clr_en_r <= wdt_pkg::RET_CLR_EN_RST;
    end else if (CE_I && WR_I && ADDR_I == wdt_pkg::CTRL_ADDR) begin
      ret_clr_en_r <= WDATA_I[wdt_pkg::CTRL_RET_CLR_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // countdown

  // there is no software stop: only reset, retention or expiry clear it
  wdt_counter #(
    .CNT_W(CNT_W)
  ) u_counter (
    .clk_i(CLOCK_I),
    .rstn_i(RSTN_I),
    .ce_i(CE_I),
    .clear_i(ret_clear),
    .load_i(commit),
    .load_val_i(load_val),
    .tick_i(LF_TICK_I),
    .run_o(cnt_run),
    .count_o(),
    .expire_o(cnt_expire)
  );

  // active flag mirrors the counter, one cycle later, from a flop
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      active_r <= 1'b0;
    end else if (CE_I) begin
      active_r <= cnt_run;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // reset request

  // held until the system reset it causes comes back on the reset input,
  // so the request always spans the whole reset tree like a pin reset
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      reset_req_r <= 1'b0;
    end else if (CE_I && cnt_expire) begin
      reset_req_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read path

  // read data stand one cycle after the strobe, are zero after any other enabled cycle, and hold while CE_I is low
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      rdata_r <= '0;
    end else if (CE_I) begin
      rdata_r <= '0;
      if (sv_rd) begin
        if (ptr_eff == wdt_pkg::WDT_BYTE_LOW) begin
          rdata_r <= start_value_r[wdt_pkg::DATA_W-1:0];
        end else begin
          rdata_r <= start_value_r[SV_W-1:wdt_pkg::DATA_W];
        end
      end else if (RD_I && ADDR_I == wdt_pkg::CTRL_ADDR) begin
        rdata_r[wdt_pkg::CTRL_RET_CLR_BIT] <= ret_clr_en_r;
      end else if (RD_I && ADDR_I == wdt_pkg::STATUS_ADDR) begin
        rdata_r[wdt_pkg::STAT_ACTIVE_BIT] <= active_r;
        rdata_r[wdt_pkg::STAT_WPTR_BIT] <=
          (op_r == wdt_pkg::WDT_OP_WRITE) && (ptr_r == wdt_pkg::WDT_BYTE_HIGH);
        rdata_r[wdt_pkg::STAT_RPTR_BIT] <=
          (op_r == wdt_pkg::WDT_OP_READ) && (ptr_r == wdt_pkg::WDT_BYTE_HIGH);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign RDATA_O = rdata_r;
  assign WDT_ACTIVE_O = active_r;
  assign WDT_RESET_O = reset_req_r;

endmodule

// >>> sim/wdt_top_checker.sv
`timescale 1ns/1ps

module wdt_top_checker (
  input wire logic CLOCK_I,                      // clock
  input wire logic RSTN_I,                       // reset, active low
  input wire logic CE_I,                         // clock enable
  input wire logic LF_TICK_I,                    // slow tick
  input wire logic RET_ENTRY_I,                  // retention entry
  input wire logic [wdt_pkg::ADDR_W-1:0] ADDR_I, // address
  input wire logic [wdt_pkg::DATA_W-1:0] WDATA_I, // write data
  input wire logic WR_I,                         // write strobe
  input wire logic RD_I,                         // read strobe
  input wire logic [wdt_pkg::DATA_W-1:0] RDATA_O, // read data
  input wire logic WDT_ACTIVE_O,                 // counting
  input wire logic WDT_RESET_O                   // reset request
);
  logic [8:0] tick_n_r;

  // ticks seen while active; saturates so a long run cannot wrap
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I || !WDT_ACTIVE_O) tick_n_r <= 9'h000;
    else if (LF_TICK_I && CE_I && !tick_n_r[8]) tick_n_r <= tick_n_r + 9'h001;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);
  sequence rd_taken;
    RD_I && CE_I;
  endsequence

  chk_rdata_idle: assert property (not $past(RD_I && CE_I) |-> RDATA_O == 8'h00)
    else $error("read data not idle");
  chk_reset_clear: assert property ($rose(RSTN_I) |-> !WDT_ACTIVE_O && !WDT_RESET_O)
    else $error("watchdog alive after reset");
  chk_expire_tick: assert property ($rose(WDT_RESET_O) |-> $past(LF_TICK_I && CE_I, 2))
    else $error("expiry not caused by a tick");
  chk_reset_hold: assert property (WDT_RESET_O |=> WDT_RESET_O)
    else $error("reset request dropped");
  chk_expire_active: assert property ($rose(WDT_RESET_O) |-> $past(WDT_ACTIVE_O))
    else $error("expiry while disabled");
  chk_start_write: assert property ($rose(WDT_ACTIVE_O) |-> $past(WR_I) || $past(WR_I, 2) || $past(WR_I, 3))
    else $error("start without a write");
  chk_stop_cause: assert property ($fell(WDT_ACTIVE_O) |-> WDT_RESET_O || $past(RET_ENTRY_I) || $past(RET_ENTRY_I, 2) || $past(RET_ENTRY_I, 3))
    else $error("watchdog stopped without cause");
  chk_min_timeout: assert property ($rose(WDT_RESET_O) |-> tick_n_r >= 9'd254)
    else $error("timeout shorter than minimum");
  cover property (rd_taken ##1 RDATA_O != 8'h00);
endmodule

bind wdt_top wdt_top_checker u_chk (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I),
  .CE_I(CE_I), .LF_TICK_I(LF_TICK_I), .RET_ENTRY_I(RET_ENTRY_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .WDT_ACTIVE_O(WDT_ACTIVE_O), .WDT_RESET_O(WDT_RESET_O));

// >>> sim/testbench.sv
`timescale 1ns/1ps

module testbench;
  logic clk, rstn, lf, ret, wr, rd, ce;
  logic [7:0] addr, wdata, rdata, d;
  logic act, wrst;
  int failures = 0;
  int num_checks = 0;
  wire [7:0] status = {6'h00, wrst, act};

  // clock enable is driven so that a frozen cycle can be shown to do nothing
  wdt_top dut (.CLOCK_I(clk), .RSTN_I(rstn), .CE_I(ce), .LF_TICK_I(lf),
    .RET_ENTRY_I(ret), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .WDT_ACTIVE_O(act), .WDT_RESET_O(wrst));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr_b(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_b(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic sv(input logic [15:0] v);
    wr_b(8'haf, v[7:0]);
    wr_b(8'haf, v[15:8]);
  endtask

  task automatic rsv(input logic [15:0] v);
    rd_b(8'haf);
    check(d, v[7:0]);
    rd_b(8'haf);
    check(d, v[15:8]);
  endtask

  // one tick is a single-cycle pulse, two cycles apart
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      lf <= 1'b1;
      @(posedge clk);
      lf <= 1'b0;
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rstn = 1'b0;
    {lf, ret, wr, rd} = 4'h0;
    ce = 1'b1;
    {addr, wdata} = 16'h0000;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    settle(1);
    check(status, 8'h00);
    rsv(16'h0000);
    rd_b(8'h00);
    check(d, 8'h00); // unmapped place reads zero
    wr_b(8'haf, 8'h34);
    settle(4);
    check(status, 8'h00);
    rd_b(8'haf);
    sv(16'h0001);
    settle(2);
    check(status, 8'h01);
    rsv(16'h0001);
    // a reload in mid-count must restart the full span
    ticks(200);
    sv(16'h0001);
    ticks(255);
    settle(50);
    check(status, 8'h01);
    ticks(1);
    settle(2);
    check(status, 8'h02);
    settle(20);
    check(status, 8'h02);
    rstn <= 1'b0;
    settle(2);
    rstn <= 1'b1;
    settle(1);
    check(status, 8'h00);
    rsv(16'h0000);
    wr_b(8'haf, 8'h00);
    settle(4);
    check(status, 8'h00);
    wr_b(8'haf, 8'h00);
    ticks(300);
    check(status, 8'h01);
    rd_b(8'hb1);
    check(d, 8'h01);
    // a retention request during a frozen cycle must be ignored
    @(posedge clk);
    ce <= 1'b0;
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    ce <= 1'b1;
    settle(3);
    check(status, 8'h01);
    // with the option off, retention entry leaves the count running
    wr_b(8'hb0, 8'h00);
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    settle(3);
    check(status, 8'h01);
    wr_b(8'hb0, 8'h01);
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    settle(3);
    check(status, 8'h00);
    end_of_test();
  end

  // hang guard, well above the roughly 1650 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule
